/* rtl/level_vector_interrupt_control.sv */
// interrupt level, mask, priority and vector control with an axi4-lite
// register slave; assumes one clock, sources give one-cycle pulses and
// the cpu core pulses its enable, disable and acknowledge lines.
// What this block does
// - boot at 0100H unless relocation strap set
// - vectors are 16-bit pointers in program ROM
// - basic timer overflow resets via 100H, no level
// - level five holds four serial sources E8H-EEH
// - in-level priority zero is serviced first
// - lowest vector wins among same-level requests
// - enable instruction turns whole structure on
// - disable instruction stops all servicing anytime
// - enable and disable instructions drive mode bit 0
// - writing mode bit 0 equals the instructions
// - one mask bit per level gates servicing
// - levels ordered in groups A, B, C
// - read-only request register, one flag per level
// - mode register holds fast, global, memory controls
// - each source gated by its own enable
// - grant disables interrupts, hands vector pointer pair
`include "lvic_consts.svh"
module level_vector_interrupt_control #(
    parameter int ADDR_W = 8
) (
    // clock, reset and freeze
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // axi4-lite write channels
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read channels
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // interrupt sources and straps
    input wire logic [`SRC_COUNT-1:0] src_pulse,
    input wire logic bt_overflow,
    input wire logic reloc_en,
    input wire lvic_pkg::addr16_t reloc_addr,
    // cpu core side
    input wire logic global_enable_instr,
    input wire logic global_disable_instr,
    input wire logic int_ack,
    output logic int_req,
    output logic [2:0] int_level,
    output lvic_pkg::addr16_t int_vec_lo,
    output lvic_pkg::addr16_t int_vec_hi,
    output logic sys_reset_req,
    output lvic_pkg::addr16_t boot_addr,
    output logic fast_int_en,
    output logic [1:0] ext_mem_ctrl,
    output logic irq
);
    import lvic_pkg::*;
    localparam int NS = `SRC_COUNT;

    default clocking cb @(posedge ref_clk iff clk_en);
    endclocking
    default disable iff (!reset_n);

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------
    // first source index of each level; index order equals vector order within a level
    function automatic logic [4:0] lvl_first(input logic [3:0] l);
        case (l)
            4'd0: lvl_first = 5'd0;
            4'd1: lvl_first = 5'd2;
            4'd2: lvl_first = 5'd3;
            4'd3: lvl_first = 5'd5;
            4'd4: lvl_first = 5'd9;
            4'd5: lvl_first = 5'd11;
            4'd6: lvl_first = 5'd15;
            4'd7: lvl_first = 5'd23;
            default: lvl_first = 5'd31;
        endcase
    endfunction

    function automatic logic [NS-1:0] lvl_srcs(input logic [2:0] l);
        logic [4:0] lo;
        logic [4:0] hi;
        lo = lvl_first({1'b0, l});
        hi = lvl_first({1'b0, l} + 4'd1);
        lvl_srcs = '0;
        for (int i = 0; i < NS; i++) begin
            lvl_srcs[i] = (5'(i) >= lo) && (5'(i) < hi);
        end
    endfunction

    // source index to vector byte address
    function automatic logic [7:0] src_vec(input logic [4:0] s);
        if (s >= `SRC_FIRST_HI) begin
            src_vec = `VEC_BASE_HI + {2'b0, s - `SRC_FIRST_HI, 1'b0};
        end else if (s >= `SRC_FIRST_MID) begin
            src_vec = `VEC_BASE_MID + {2'b0, s - `SRC_FIRST_MID, 1'b0};
        end else begin
            src_vec = `VEC_BASE_LO + {2'b0, s, 1'b0};
        end
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] nw, input logic [3:0] be);
        merge = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                merge[8*b +: 8] = nw[8*b +: 8];
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [3:0] system_mode_reg, system_mode_next;
    logic [7:0] level_mask_reg;
    logic [2:0] level_priority_reg;
    logic [NS-1:0] src_en_reg, src_pend_reg, src_pend_next;
    logic [1:0] evt_status_reg, evt_status_next, evt_enable_reg;
    logic [2:0] int_level_reg;
    addr16_t vec_lo_reg, boot_addr_reg;
    logic boot_done_reg, sys_reset_req_reg;
    logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0] w_data_reg, rdata_reg;
    logic [3:0] w_strb_reg;
    logic [1:0] bresp_reg, rresp_reg;

    // ----------------------------------------------------------------
    // bus slave decode
    // ----------------------------------------------------------------
    // write runs the cycle after both address and data are held
    wire do_write = aw_full_reg && w_full_reg && !bvalid_reg;
    wire ar_take = arvalid && arready;
    wire [7:0] wa = 8'(aw_addr_reg);
    wire [7:0] ra = 8'(araddr);
    wire wr_sym = do_write && wa == `OFS_SYS_MODE;
    wire wr_mask = do_write && wa == `OFS_LEVEL_MASK;
    wire wr_prio = do_write && wa == `OFS_LEVEL_PRIO;
    wire wr_sen = do_write && wa == `OFS_SRC_ENABLE;
    wire wr_sclr = do_write && wa == `OFS_SRC_CLEAR;
    wire wr_eclr = do_write && wa == `OFS_EVT_CLEAR;
    wire wr_een = do_write && wa == `OFS_EVT_ENABLE;
    // read-only offsets accept writes silently; unmapped ones refuse
    wire wr_ok = wr_sym | wr_mask | wr_prio | wr_sen | wr_sclr | wr_eclr
        | wr_een | wa == `OFS_LEVEL_REQ | wa == `OFS_SRC_PEND
        | wa == `OFS_GRANT_VEC | wa == `OFS_EVT_STATUS;
    wire [31:0] m_sym = merge({28'h0, system_mode_reg}, w_data_reg,
        w_strb_reg);
    wire [31:0] m_mask = merge({24'h0, level_mask_reg}, w_data_reg,
        w_strb_reg);
    wire [31:0] m_prio = merge({29'h0, level_priority_reg}, w_data_reg,
        w_strb_reg);
    wire [31:0] m_sen = merge({1'b0, src_en_reg}, w_data_reg, w_strb_reg);
    wire [31:0] m_clr = merge(32'h0, w_data_reg, w_strb_reg);
    wire [31:0] m_een = merge({30'h0, evt_enable_reg}, w_data_reg,
        w_strb_reg);

    assign awready = clk_en && !aw_full_reg && !bvalid_reg;
    assign wready = clk_en && !w_full_reg && !bvalid_reg;
    assign arready = clk_en && !rvalid_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign rvalid = rvalid_reg;
    assign rresp = rresp_reg;
    assign rdata = rdata_reg;

    // ----------------------------------------------------------------
    // arbitration
    // ----------------------------------------------------------------
    wire gie = system_mode_reg[`SYM_GIE_BIT];
    wire [NS-1:0] src_act = src_pend_reg & src_en_reg;
    logic [7:0] level_req;
    for (genvar l = 0; l < 8; l++) begin : g_lvl
        assign level_req[l] = |(src_act & lvl_srcs(3'(l)));
    end
    wire [7:0] elig = level_req & level_mask_reg & {8{gie}};
    wire any_a = |elig[1:0];
    wire any_b = |elig[4:2];
    wire any_c = |elig[7:5];

    // group order codes 0..5 are the six orders; others fall back to A,B,C
    grp_t g1, g2, g3, win_grp;
    always_comb begin
        case (level_priority_reg)
            3'd1: begin g1 = GRP_A; g2 = GRP_C; g3 = GRP_B; end
            3'd2: begin g1 = GRP_B; g2 = GRP_A; g3 = GRP_C; end
            3'd3: begin g1 = GRP_B; g2 = GRP_C; g3 = GRP_A; end
            3'd4: begin g1 = GRP_C; g2 = GRP_A; g3 = GRP_B; end
            3'd5: begin g1 = GRP_C; g2 = GRP_B; g3 = GRP_A; end
            default: begin g1 = GRP_A; g2 = GRP_B; g3 = GRP_C; end
        endcase
    end
    wire [2:0] g_any = {any_c, any_b, any_a};
    assign win_grp = |(g1 & g_any) ? g1 : |(g2 & g_any) ? g2 : g3;
    wire [7:0] grp_lv = {{3{win_grp[2]}}, {3{win_grp[1]}}, {2{win_grp[0]}}};
    wire [7:0] cand_lv = elig & grp_lv;

    // lowest level in the group, then lowest index (lowest vector) in it
    logic [2:0] win_level;
    logic [4:0] win_src;
    always_comb begin
        win_level = 3'd0;
        for (int l = 7; l >= 0; l--) begin
            if (cand_lv[l]) win_level = 3'(l);
        end
    end
    wire [NS-1:0] cand_src = src_act & lvl_srcs(win_level);
    always_comb begin
        win_src = 5'd0;
        for (int i = NS - 1; i >= 0; i--) begin
            if (cand_src[i]) win_src = 5'(i);
        end
    end

    assign int_req = |elig;
    wire grant = int_req && int_ack && clk_en;
    wire [NS-1:0] win_hot = NS'(1) << win_src;
    // software clears any flag; hardware clears the winner's on grant only if it is in HW_CLR_MASK
    wire [NS-1:0] pend_clr = (wr_sclr ? m_clr[NS-1:0] : '0)
        | (grant ? (win_hot & `HW_CLR_MASK) : '0);
    assign src_pend_next = (src_pend_reg & ~pend_clr) | src_pulse;
    assign evt_status_next = (evt_status_reg & ~(wr_eclr ? m_clr[1:0] : 2'b0))
        | {bt_overflow, grant};

    // mode bit: bus write, then grant, then instructions; disable last
    always_comb begin
        system_mode_next = system_mode_reg;
        if (wr_sym) system_mode_next = m_sym[3:0];
        if (grant) system_mode_next[`SYM_GIE_BIT] = 1'b0;
        if (global_enable_instr) system_mode_next[`SYM_GIE_BIT] = 1'b1;
        if (global_disable_instr) system_mode_next[`SYM_GIE_BIT] = 1'b0;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // control registers; mask writes are not blocked, keeping order is
    // software's job (global disable first)
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            system_mode_reg <= `SYS_MODE_RST;
            level_mask_reg <= `LEVEL_MASK_RST;
            level_priority_reg <= `LEVEL_PRIO_RST;
            src_en_reg <= `SRC_EN_RST;
            evt_enable_reg <= 2'h0;
        end else if (clk_en) begin
            system_mode_reg <= system_mode_next;
            if (wr_mask) level_mask_reg <= m_mask[7:0];
            if (wr_prio) level_priority_reg <= m_prio[2:0];
            if (wr_sen) src_en_reg <= m_sen[NS-1:0];
            if (wr_een) evt_enable_reg <= m_een[1:0];
        end
    end

    // pending flags, events and grant capture
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            src_pend_reg <= '0;
            evt_status_reg <= 2'h0;
            int_level_reg <= 3'd0;
            vec_lo_reg <= 16'h0000;
            sys_reset_req_reg <= 1'b0;
        end else if (clk_en) begin
            src_pend_reg <= src_pend_next;
            evt_status_reg <= evt_status_next;
            sys_reset_req_reg <= bt_overflow;
            if (grant) begin
                int_level_reg <= win_level;
                vec_lo_reg <= {8'h00, src_vec(win_src)};
            end
        end
    end

    // boot address caught on the first enabled edge after release
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            boot_done_reg <= 1'b0;
            boot_addr_reg <= `RESET_ADDR;
        end else if (clk_en && !boot_done_reg) begin
            boot_done_reg <= 1'b1;
            boot_addr_reg <= reloc_en ? reloc_addr : `RESET_ADDR;
        end
    end

    // bus write path
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            bresp_reg <= `RESP_OKAY;
        end else if (clk_en) begin
            if (awvalid && awready) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= awaddr;
            end
            if (wvalid && wready) begin
                w_full_reg <= 1'b1;
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
            end
            if (do_write) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // read data selection
    wire [31:0] rd_val =
        ra == `OFS_SYS_MODE ? {28'h0, system_mode_reg} :
        ra == `OFS_LEVEL_MASK ? {24'h0, level_mask_reg} :
        ra == `OFS_LEVEL_PRIO ? {29'h0, level_priority_reg} :
        ra == `OFS_LEVEL_REQ ? {24'h0, level_req} :
        ra == `OFS_SRC_ENABLE ? {1'b0, src_en_reg} :
        ra == `OFS_SRC_PEND ? {1'b0, src_pend_reg} :
        ra == `OFS_GRANT_VEC ? {13'h0, int_level_reg, vec_lo_reg} :
        ra == `OFS_EVT_STATUS ? {30'h0, evt_status_reg} :
        ra == `OFS_EVT_ENABLE ? {30'h0, evt_enable_reg} : 32'h0;
    wire rd_ok = ra == `OFS_SYS_MODE || ra == `OFS_LEVEL_MASK
        || ra == `OFS_LEVEL_PRIO || ra == `OFS_LEVEL_REQ
        || ra == `OFS_SRC_ENABLE || ra == `OFS_SRC_PEND
        || ra == `OFS_GRANT_VEC || ra == `OFS_EVT_STATUS
        || ra == `OFS_EVT_ENABLE || ra == `OFS_SRC_CLEAR
        || ra == `OFS_EVT_CLEAR;

    // bus read path
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= `RESP_OKAY;
        end else if (clk_en) begin
            if (ar_take) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_val;
                rresp_reg <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end else if (rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign int_level = int_level_reg;
    assign int_vec_lo = vec_lo_reg;
    assign int_vec_hi = vec_lo_reg + 16'h0001;
    assign sys_reset_req = sys_reset_req_reg;
    assign boot_addr = boot_addr_reg;
    assign fast_int_en = system_mode_reg[`SYM_FAST_BIT];
    assign ext_mem_ctrl = system_mode_reg[`SYM_EXT_LSB +: 2];
    assign irq = |(evt_status_reg & evt_enable_reg);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence grant_s;
        int_req && int_ack;
    endsequence

    boot_addr_a: assert property (boot_done_reg && !reloc_en ##1
        $stable(boot_done_reg) |-> boot_addr == `RESET_ADDR
        || $past(reloc_en)) else $error("boot address wrong");
    bt_reset_a: assert property (bt_overflow |=> sys_reset_req
        && $stable(level_mask_reg)) else $error("no reset pulse");
    vec_pair_a: assert property (grant_s |=>
        int_vec_hi == int_vec_lo + 1 && int_vec_lo[15:8] == 8'h00)
        else $error("bad pointer");
    grant_off_a: assert property (grant_s ##0 !global_enable_instr
        |=> !int_req) else $error("grant kept enable");
    // a re-enable after the disable may legally raise the request again
    di_stop_a: assert property (global_disable_instr |=> !int_req ##1
        (!int_req || $past(global_enable_instr || wr_sym)))
        else $error("serviced while disabled");
    ei_set_a: assert property (global_enable_instr
        && !global_disable_instr |=> system_mode_reg[`SYM_GIE_BIT])
        else $error("ei ignored");
    mask_gate_a: assert property (int_req |-> gie
        && (level_req & level_mask_reg) != 8'h00) else $error("ungated");
    level5_vec_a: assert property (grant_s ##0 win_level == 3'd5 |=>
        int_vec_lo >= 16'h00E8 && int_vec_lo <= 16'h00EE)
        else $error("level five vector");
    in_level_a: assert property (grant_s |-> (cand_src
        & (win_hot - 1'b1)) == '0) else $error("not lowest vector");
endmodule // level_vector_interrupt_control

/* rtl/lvic_consts.svh */
// constants for the level and vector interrupt controller
// assumes inclusion by bare name from the design file and the bench
`ifndef LVIC_CONSTS_SVH
`define LVIC_CONSTS_SVH
// boot and reset vectors
`define RESET_ADDR 16'h0100
`define BT_VECTOR 16'h0100
// vector bases: levels 0-3, levels 4-6, level 7
`define VEC_BASE_LO 8'hCE
`define VEC_BASE_MID 8'hE4
`define VEC_BASE_HI 8'hB0
`define SRC_FIRST_MID 5'h09
`define SRC_FIRST_HI 5'h17
`define SRC_COUNT 31
// sources whose pending flag hardware clears on grant
`define HW_CLR_MASK 31'h0000015E
// register byte offsets
`define OFS_SYS_MODE 8'h00
`define OFS_LEVEL_MASK 8'h04
`define OFS_LEVEL_PRIO 8'h08
`define OFS_LEVEL_REQ 8'h0C
`define OFS_SRC_ENABLE 8'h10
`define OFS_SRC_PEND 8'h14
`define OFS_SRC_CLEAR 8'h18
`define OFS_GRANT_VEC 8'h1C
`define OFS_EVT_STATUS 8'h20
`define OFS_EVT_CLEAR 8'h24
`define OFS_EVT_ENABLE 8'h28
// system mode fields
`define SYM_GIE_BIT 0
`define SYM_FAST_BIT 1
`define SYM_EXT_LSB 2
// reset values
`define SYS_MODE_RST 4'h0
`define LEVEL_MASK_RST 8'h00
`define LEVEL_PRIO_RST 3'h0
`define SRC_EN_RST 31'h00000000
// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* rtl/lvic_pkg.sv */
// types shared by the interrupt controller
// assumes the constants header sits beside it
package lvic_pkg;
    // priority groups, one-hot
    typedef enum logic [2:0] {
        GRP_A = 3'b001,
        GRP_B = 3'b010,
        GRP_C = 3'b100
    } grp_t;
    typedef logic [15:0] addr16_t;
endpackage

/* bench/lvic_core_model.sv */
// behavioural cpu core that acknowledges a standing interrupt request
// assumes the controller's single clock and active-low async reset
module lvic_core_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // controls from the bench
    input wire logic auto_ack,
    input wire logic [3:0] ack_delay,
    // interrupt handshake
    input wire logic int_req,
    output logic int_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // acknowledge logic
    // ------------------------------------------------------------
    logic [3:0] wait_cnt;
    // acks a request that stood ack_delay+1 cycles, as a slow core would
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            int_ack <= 1'h0;
            wait_cnt <= 4'h0;
        end else if (int_ack) begin
            int_ack <= 1'h0;
            wait_cnt <= 4'h0;
        end else if (int_req && auto_ack) begin
            if (wait_cnt == ack_delay) begin
                int_ack <= 1'h1;
            end else begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end else begin
            wait_cnt <= 4'h0;
        end
    end
endmodule // lvic_core_model

/* bench/level_vector_interrupt_control_tb.sv */
// self-checking bench for the level and vector interrupt controller
// assumes the design's header and package
`include "lvic_consts.svh"
`define CHECK_EQ(got, exp, msg) begin n_tests++; \
    if ((got) !== (exp)) begin err_count++; \
    $display("wrong value at %0t: %s", $time, msg); end end
module level_vector_interrupt_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lvic_pkg::*;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic ref_clk = 1'h0;
    logic reset_n = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, bt_overflow = 1'h0;
    logic gie_on = 1'h0, gie_off = 1'h0, auto_ack = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, int_req, int_ack;
    logic sys_reset_req, fast_int_en, irq;
    logic [1:0] bresp, rresp, ext_mem_ctrl, rsp;
    logic [30:0] src_pulse = 31'h0;
    logic [3:0] ack_delay = 4'h0;
    logic [2:0] int_level;
    addr16_t int_vec_lo, int_vec_hi, boot_addr;
    int err_count = 0, n_tests = 0, cycles = 0;
    level_vector_interrupt_control level_vector_interrupt_control_i (
        .ref_clk, .reset_n, .clk_en(1'h1), .awaddr, .awvalid, .awready,
        .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .src_pulse, .bt_overflow, .reloc_en(1'h0), .reloc_addr(16'h0000),
        .global_enable_instr(gie_on), .global_disable_instr(gie_off),
        .int_ack, .int_req, .int_level, .int_vec_lo, .int_vec_hi,
        .sys_reset_req, .boot_addr, .fast_int_en, .ext_mem_ctrl, .irq);
    lvic_core_model lvic_core_model_i (.ref_clk, .reset_n, .auto_ack,
        .ack_delay, .int_req, .int_ack);
    // 250 MHz clock and a cycle ceiling against hangs
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            give_verdict();
        end
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    // ready is read at the rising edge that takes the item; each
    // channel is released right after its own handshake edge
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic aw_due = 1'h1, w_due = 1'h1;
        @(posedge ref_clk);
        {awaddr, wdata} <= {a, d};
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge ref_clk);
            aw_due = aw_due && awready !== 1'h1;
            w_due = w_due && wready !== 1'h1;
            {awvalid, wvalid} <= {aw_due, w_due};
        end while (aw_due || w_due);
        do @(posedge ref_clk); while (bvalid !== 1'h1);
        rsp = bresp;
        bready <= 1'h0;
    endtask
    task automatic axi_read(input logic [7:0] a);
        @(posedge ref_clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(posedge ref_clk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge ref_clk); while (rvalid !== 1'h1);
        {rd, rsp} = {rdata, rresp};
        rready <= 1'h0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                          input string m);
        axi_read(a);
        `CHECK_EQ(rd, e, m)
        `CHECK_EQ(rsp, `RESP_OKAY, m)
    endtask
    task automatic pulse(input logic [30:0] m);
        @(posedge ref_clk) src_pulse <= m;
        @(posedge ref_clk) src_pulse <= 31'h0;
    endtask
    task automatic core_instr(input logic on);
        @(posedge ref_clk) {gie_on, gie_off} <= {on, !on};
        @(posedge ref_clk) {gie_on, gie_off} <= 2'h0;
    endtask
    // waits for the core's ack, then judges the vector
    task automatic take_grant(input logic [15:0] v, input logic [2:0] l,
                              input string m);
        do @(negedge ref_clk); while (int_ack !== 1'h1);
        @(negedge ref_clk);
        `CHECK_EQ(int_vec_lo, v, m)
        `CHECK_EQ(int_vec_hi, v + 16'h0001, m)
        `CHECK_EQ(int_level, l, m)
        `CHECK_EQ(int_req, 1'h0, m)
    endtask
    function automatic logic [15:0] vec_of(input int i);
        if (i < 9) return 16'h00CE + 16'(2 * i);
        if (i < 15) return 16'h00E4 + 16'(2 * (i - 9));
        if (i < 23) return 16'h00F0 + 16'(2 * (i - 15));
        return 16'h00B0 + 16'(2 * (i - 23));
    endfunction
    function automatic logic [2:0] lvl_of(input int i);
        int lim[8] = '{1, 2, 4, 8, 10, 14, 22, 30};
        for (int l = 0; l < 8; l++) begin
            if (i <= lim[l]) return 3'(l);
        end
        return 3'h0;
    endfunction
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        `CHECK_EQ(boot_addr, 16'h0100, "boot address")
        `CHECK_EQ(int_req, 1'h0, "idle request")
        rd_chk(`OFS_SYS_MODE, 32'h0, "mode reset");
        axi_write(`OFS_SYS_MODE, 32'hE);
        `CHECK_EQ({fast_int_en, ext_mem_ctrl}, 3'h7, "mode fields")
        rd_chk(`OFS_SYS_MODE, 32'hE, "mode readback");
        axi_write(`OFS_SYS_MODE, 32'h0);
        axi_write(`OFS_LEVEL_REQ, 32'hFF);
        `CHECK_EQ(rsp, `RESP_OKAY, "ro write")
        rd_chk(`OFS_LEVEL_REQ, 32'h0, "ro flags");
        axi_read(8'h40);
        `CHECK_EQ(rsp, `RESP_SLVERR, "unmapped read")
    endtask
    task automatic t_timer();
        axi_write(`OFS_EVT_ENABLE, 32'h2);
        for (int k = 0; k < 2; k++) begin
            @(posedge ref_clk) bt_overflow <= 1'h1;
            @(posedge ref_clk) bt_overflow <= 1'h0;
            @(negedge ref_clk);
            `CHECK_EQ(sys_reset_req, 1'h1, "bt pulse")
            @(negedge ref_clk);
            `CHECK_EQ(sys_reset_req, 1'h0, "bt end")
            `CHECK_EQ({irq, int_req}, {!k[0], 1'h0}, "timer event")
            rd_chk(`OFS_EVT_STATUS, 32'h2, "timer status");
            axi_write(`OFS_EVT_CLEAR, 32'h2);
            @(negedge ref_clk);
            `CHECK_EQ(irq, 1'h0, "event cleared")
            axi_write(`OFS_EVT_ENABLE, 32'h0);
        end
    endtask
    task automatic t_level5();
        axi_write(`OFS_SRC_ENABLE, 32'h7800);
        axi_write(`OFS_LEVEL_MASK, 32'h20);
        pulse(31'h7800);
        rd_chk(`OFS_LEVEL_REQ, 32'h20, "level flag");
        `CHECK_EQ(int_req, 1'h0, "global enable off")
        auto_ack <= 1'h1;
        for (int k = 0; k < 4; k++) begin
            ack_delay <= 4'(3 * k);
            core_instr(1'h1);
            take_grant(16'h00E8 + 16'(2 * k), 3'h5, "serial");
            rd_chk(`OFS_SRC_PEND, (32'h7800 << k) & 32'h7800, "sw");
            axi_write(`OFS_SRC_CLEAR, 32'h800 << k);
        end
    endtask
    task automatic t_map();
        axi_write(`OFS_SRC_ENABLE, 32'h7FFFFFFF);
        axi_write(`OFS_LEVEL_MASK, 32'hFF);
        for (int i = 0; i < 31; i++) begin
            axi_write(`OFS_SYS_MODE, 32'h1);
            pulse(31'h1 << i);
            take_grant(vec_of(i), lvl_of(i), "vector map");
            axi_write(`OFS_SRC_CLEAR, 32'h1 << i);
        end
        rd_chk(`OFS_SYS_MODE, 32'h0, "grant clr");
    endtask
    task automatic t_prio();
        int w[8] = '{0, 0, 3, 3, 11, 11, 0, 0};
        for (int c = 0; c < 8; c++) begin
            axi_write(`OFS_LEVEL_PRIO, 32'(c));
            pulse(31'h809);
            core_instr(1'h1);
            take_grant(vec_of(w[c]), lvl_of(w[c]), "group");
            axi_write(`OFS_SRC_CLEAR, 32'h7FFFFFFF);
        end
    endtask
    task automatic t_gate();
        auto_ack <= 1'h0;
        axi_write(`OFS_SYS_MODE, 32'h1);
        pulse(31'h800);
        @(negedge ref_clk);
        `CHECK_EQ(int_req, 1'h1, "eligible")
        core_instr(1'h0);
        @(negedge ref_clk);
        `CHECK_EQ(int_req, 1'h0, "global off")
        rd_chk(`OFS_SYS_MODE, 32'h0, "di bit");
        axi_write(`OFS_LEVEL_MASK, 32'hDF);
        core_instr(1'h1);
        @(negedge ref_clk);
        `CHECK_EQ(int_req, 1'h0, "level masked")
        core_instr(1'h0);
        axi_write(`OFS_LEVEL_MASK, 32'hFF);
        axi_write(`OFS_SRC_ENABLE, 32'h7FFFF7FF);
        core_instr(1'h1);
        @(negedge ref_clk);
        `CHECK_EQ(int_req, 1'h0, "src off")
        rd_chk(`OFS_SYS_MODE, 32'h1, "ei bit");
        axi_write(`OFS_SRC_ENABLE, 32'h7FFFFFFF);
        @(negedge ref_clk);
        `CHECK_EQ(int_req, 1'h1, "src on")
    endtask
    // ------------------------------------------------------------
    // main sequence and verdict
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("mismatches %0d, comparisons %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'h1;
        t_reset();
        t_timer();
        t_level5();
        t_map();
        t_prio();
        t_gate();
        give_verdict();
    end
endmodule // level_vector_interrupt_control_tb
